// File: src/ptm_pkg.sv
/*
  Constants for the paired 16/32-bit timer block: register map, control fields,
  prescale ratios and reset values.
  Assumes an APB slave with 32-bit data, each register one aligned word.
*/
// Summary of operation
// - Low-word timer synchronizes external clock after the prescaler.
// - High-word timer synchronizes external clock before the prescaler.
// - High-word timer gives a conversion trigger pulse on its period event.
// - Source bit 1 and gate bit 6 select timer, gated or counter mode.
// - Timer modes count the instruction clock; counter mode counts pin rising edges.
// - Prescale field divides by 1, 8, 64 or 256.
// - Gate bit acts only with the internal clock selected.
// - Concatenation bit 3 of low-word control joins the pair into 32 bits.
// - High-word count holds upper half, low-word count lower half.
// - In 32-bit mode only low-word control governs, except high stop-in-idle.
// - In 32-bit mode the high-word interrupt enable, flag, priority serve the pair.
// - Fixed pairs; the even-numbered timer supplies the lower word.
// - 32-bit period is high period upper half, low period lower half.
// - Low-word on bit starts or stops the pair or the single timer.
// - Stop-in-idle set halts the timer during idle mode.
// - Only the second/third timer pair issues transfer requests.
// - Unimplemented control bits ignore writes and read as zero.
package ptm_pkg;
  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] PTM_LO_CTRL_OFS = 8'h00;
  localparam logic [7:0] PTM_HI_CTRL_OFS = 8'h04;
  localparam logic [7:0] PTM_LO_COUNT_OFS = 8'h08;
  localparam logic [7:0] PTM_HI_COUNT_OFS = 8'h0C;
  localparam logic [7:0] PTM_LO_PERIOD_OFS = 8'h10;
  localparam logic [7:0] PTM_HI_PERIOD_OFS = 8'h14;
  localparam logic [7:0] PTM_IRQ_OFS = 8'h18;
  // ----------------------------------------------------------------
  // Control fields
  // ----------------------------------------------------------------
  localparam int PTM_RUN_BIT = 15;
  localparam int PTM_IDLE_BIT = 13;
  localparam int PTM_GATE_BIT = 6;
  localparam int PTM_PS_HI = 5;
  localparam int PTM_PS_LO = 4;
  localparam int PTM_CONCAT_BIT = 3;
  localparam int PTM_SRC_BIT = 1;
  localparam logic [15:0] PTM_LO_CTRL_MASK = 16'hA07A;
  localparam logic [15:0] PTM_HI_CTRL_MASK = 16'hA072;
  localparam logic [15:0] PTM_CTRL_RESET = 16'h0000;
  localparam logic [15:0] PTM_COUNT_RESET = 16'h0000;
  localparam logic [15:0] PTM_PERIOD_RESET = 16'hFFFF;
  // ----------------------------------------------------------------
  // Interrupt register fields (per timer: enable, flag, priority)
  // ----------------------------------------------------------------
  localparam int PTM_LO_IE_BIT = 0;
  localparam int PTM_LO_IF_BIT = 1;
  localparam int PTM_LO_IP_LO = 2;
  localparam int PTM_HI_IE_BIT = 8;
  localparam int PTM_HI_IF_BIT = 9;
  localparam int PTM_HI_IP_LO = 10;
  localparam int PTM_IP_W = 3;
  // ----------------------------------------------------------------
  // Prescale ratios, minus one
  // ----------------------------------------------------------------
  localparam logic [7:0] PTM_DIV1_M1 = 8'h00;
  localparam logic [7:0] PTM_DIV8_M1 = 8'h07;
  localparam logic [7:0] PTM_DIV64_M1 = 8'h3F;
  localparam logic [7:0] PTM_DIV256_M1 = 8'hFF;
  localparam logic [31:0] PTM_ZERO32 = 32'h0000_0000;

  typedef enum logic [1:0] {
    PTM_IDLE_PH,
    PTM_ACCESS_PH
  } ptm_apb_t;

  function automatic logic [7:0] ptm_ratio_m1(input logic [1:0] sel);
    case (sel)
      2'b00: ptm_ratio_m1 = PTM_DIV1_M1;
      2'b01: ptm_ratio_m1 = PTM_DIV8_M1;
      2'b10: ptm_ratio_m1 = PTM_DIV64_M1;
      default: ptm_ratio_m1 = PTM_DIV256_M1;
    endcase
  endfunction
endpackage

// File: src/ptm_timer_pair.sv
/*
  Paired timers: one low-word and one high-word 16-bit timer, joinable into
  a 32-bit timer, with an APB register slave.
  Assumes one clock pclk; ext_count pins and gate pins are asynchronous.
*/
`timescale 1ns/1ns
`default_nettype none
module ptm_timer_pair
  import ptm_pkg::*;
#(
  parameter bit DMA_CAPABLE = 1'b1
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic ext_count_pin_lo,
  input wire logic ext_count_pin_hi,
  input wire logic gate_pin_lo,
  input wire logic gate_pin_hi,
  input wire logic device_idle,
  output logic irq_lo,
  output logic irq_hi,
  output logic [2:0] irq_priority_lo,
  output logic [2:0] irq_priority_hi,
  output logic adc_trigger,
  output logic dma_req_lo,
  output logic dma_req_hi
);
  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [15:0] lo_ctrl_reg;
  logic [15:0] hi_ctrl_reg;
  logic [15:0] lo_count_reg;
  logic [15:0] hi_count_reg;
  logic [15:0] lo_period_reg;
  logic [15:0] hi_period_reg;
  logic lo_ie_reg;
  logic hi_ie_reg;
  logic lo_if_reg;
  logic hi_if_reg;
  logic [2:0] lo_ip_reg;
  logic [2:0] hi_ip_reg;
  logic [7:0] lo_ps_reg;
  logic [7:0] hi_ps_reg;
  logic [2:0] hi_pin_sync_reg;
  logic [1:0] lo_gate_sync_reg;
  logic [1:0] hi_gate_sync_reg;
  logic lo_raw_prev_reg;
  logic [1:0] lo_ps_sync_reg;
  logic lo_ps_prev_reg;
  logic lo_ps_tgl_reg;
  ptm_apb_t apb_reg;

  // ----------------------------------------------------------------
  // Effective controls
  // ----------------------------------------------------------------
  logic concat;
  logic lo_src;
  logic hi_src;
  logic lo_gated;
  logic hi_gated;
  logic lo_run;
  logic hi_run;
  logic [7:0] lo_ratio_m1;
  logic [7:0] hi_ratio_m1;

  assign concat = lo_ctrl_reg[PTM_CONCAT_BIT];
  assign lo_src = lo_ctrl_reg[PTM_SRC_BIT];
  // High-word settings follow the low-word control when joined
  assign hi_src = concat ? lo_src : hi_ctrl_reg[PTM_SRC_BIT];
  assign lo_gated = lo_ctrl_reg[PTM_GATE_BIT] && !lo_src;
  assign hi_gated = concat ? lo_gated
                  : (hi_ctrl_reg[PTM_GATE_BIT] && !hi_src);
  assign lo_ratio_m1 = ptm_ratio_m1(lo_ctrl_reg[PTM_PS_HI:PTM_PS_LO]);
  assign hi_ratio_m1 = ptm_ratio_m1(hi_ctrl_reg[PTM_PS_HI:PTM_PS_LO]);
  // Idle halt: joined pair honours only the high-word stop-in-idle bit
  assign lo_run = lo_ctrl_reg[PTM_RUN_BIT] && !(device_idle && lo_ctrl_reg[PTM_IDLE_BIT]
                  && !concat) && !(device_idle && concat && hi_ctrl_reg[PTM_IDLE_BIT]
                  );
  assign hi_run = hi_ctrl_reg[PTM_RUN_BIT] && !(device_idle && hi_ctrl_reg[PTM_IDLE_BIT]);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      hi_pin_sync_reg <= 3'h0;
      lo_gate_sync_reg <= 2'h0;
      hi_gate_sync_reg <= 2'h0;
      lo_raw_prev_reg <= 1'b0;
    end
    else
    begin
      hi_pin_sync_reg <= {hi_pin_sync_reg[1:0], ext_count_pin_hi};
      lo_gate_sync_reg <= {lo_gate_sync_reg[0], gate_pin_lo};
      hi_gate_sync_reg <= {hi_gate_sync_reg[0], gate_pin_hi};
      lo_raw_prev_reg <= ext_count_pin_lo;
    end
  end

  // Low-word external path: an asynchronous divide-by-N ahead of the sync is
  // replaced by a toggle divider clocked on pclk sampling of the raw pin,
  // then the divided toggle is synchronised (divide before sync).
  logic lo_raw_rise;
  assign lo_raw_rise = ext_count_pin_lo && !lo_raw_prev_reg;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      lo_ps_sync_reg <= 2'h0;
      lo_ps_prev_reg <= 1'b0;
    end
    else
    begin
      lo_ps_sync_reg <= {lo_ps_sync_reg[0], lo_ps_tgl_reg};
      lo_ps_prev_reg <= lo_ps_sync_reg[1];
    end
  end

  // ----------------------------------------------------------------
  // Count ticks
  // ----------------------------------------------------------------
  logic hi_ext_rise;
  logic lo_ps_wrap;
  logic hi_ps_wrap;
  logic lo_tick;
  logic hi_tick;
  logic lo_match;
  logic hi_match;
  logic lo_in;
  logic hi_in;
  assign hi_ext_rise = hi_pin_sync_reg[1] && !hi_pin_sync_reg[2];
  assign lo_in = lo_src ? 1'b0
               : (!lo_gated || lo_gate_sync_reg[1]);
  assign hi_in = hi_src ? hi_ext_rise
               : (!hi_gated || hi_gate_sync_reg[1]);
  assign lo_ps_wrap = (lo_ps_reg == lo_ratio_m1);
  assign hi_ps_wrap = (hi_ps_reg == hi_ratio_m1);
  assign lo_tick = lo_run && (lo_src ? (lo_ps_sync_reg[1] != lo_ps_prev_reg)
                                      : (lo_in && lo_ps_wrap));
  assign hi_tick = hi_run && hi_in && hi_ps_wrap;
  // Low-word (even) timer is always the lower half when joined
  assign lo_match = concat
                  ? ({hi_count_reg, lo_count_reg} == {hi_period_reg, lo_period_reg})
                  : (lo_count_reg == lo_period_reg);
  assign hi_match = (hi_count_reg == hi_period_reg);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      lo_ps_reg <= 8'h00;
      lo_ps_tgl_reg <= 1'b0;
    end
    else if (!lo_run)
    begin
      lo_ps_reg <= 8'h00;
    end
    else if (lo_src ? lo_raw_rise : lo_in)
    begin
      lo_ps_reg <= lo_ps_wrap ? 8'h00 : lo_ps_reg + 8'h01;
      if (lo_src && lo_ps_wrap)
        lo_ps_tgl_reg <= !lo_ps_tgl_reg;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      hi_ps_reg <= 8'h00;
    else if (!hi_run || concat)
      hi_ps_reg <= 8'h00;
    else if (hi_in)
      hi_ps_reg <= hi_ps_wrap ? 8'h00 : hi_ps_reg + 8'h01;
  end

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  logic wr_en;
  logic rd_en;
  logic addr_ok;
  assign addr_ok = (paddr == PTM_LO_CTRL_OFS) || (paddr == PTM_HI_CTRL_OFS)
                || (paddr == PTM_LO_COUNT_OFS) || (paddr == PTM_HI_COUNT_OFS)
                || (paddr == PTM_LO_PERIOD_OFS) || (paddr == PTM_HI_PERIOD_OFS)
                || (paddr == PTM_IRQ_OFS);
  assign wr_en = psel && penable && pwrite && (apb_reg == PTM_ACCESS_PH) && addr_ok;
  assign rd_en = psel && !penable && !pwrite;

  // ----------------------------------------------------------------
  // Counters
  // ----------------------------------------------------------------
  localparam logic [15:0] LO_WORD_MAX = 16'hFFFF;
  logic lo_event;
  logic hi_event;
  assign lo_event = lo_tick && lo_match && !concat;
  assign hi_event = concat ? (lo_tick && lo_match) : (hi_tick && hi_match);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      lo_count_reg <= PTM_COUNT_RESET;
      hi_count_reg <= PTM_COUNT_RESET;
    end
    else
    begin
      if (wr_en && paddr == PTM_LO_COUNT_OFS)
        lo_count_reg <= pwdata[15:0];
      else if (lo_tick)
        lo_count_reg <= lo_match ? PTM_COUNT_RESET : lo_count_reg + 16'h0001;
      if (wr_en && paddr == PTM_HI_COUNT_OFS)
        hi_count_reg <= pwdata[15:0];
      else if (concat && lo_tick)
      begin
        if (lo_match)
          hi_count_reg <= PTM_COUNT_RESET;
        else if (lo_count_reg == LO_WORD_MAX)
          hi_count_reg <= hi_count_reg + 16'h0001;
      end
      else if (!concat && hi_tick)
        hi_count_reg <= hi_match ? PTM_COUNT_RESET : hi_count_reg + 16'h0001;
    end
  end

  // ----------------------------------------------------------------
  // Control, period and interrupt registers
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      lo_ctrl_reg <= PTM_CTRL_RESET;
      hi_ctrl_reg <= PTM_CTRL_RESET;
      lo_period_reg <= PTM_PERIOD_RESET;
      hi_period_reg <= PTM_PERIOD_RESET;
      lo_ie_reg <= 1'b0;
      hi_ie_reg <= 1'b0;
      lo_ip_reg <= 3'h0;
      hi_ip_reg <= 3'h0;
    end
    else if (wr_en)
    begin
      case (paddr)
        PTM_LO_CTRL_OFS: lo_ctrl_reg <= pwdata[15:0] & PTM_LO_CTRL_MASK;
        PTM_HI_CTRL_OFS: hi_ctrl_reg <= pwdata[15:0] & PTM_HI_CTRL_MASK;
        PTM_LO_PERIOD_OFS: lo_period_reg <= pwdata[15:0];
        PTM_HI_PERIOD_OFS: hi_period_reg <= pwdata[15:0];
        PTM_IRQ_OFS:
        begin
          lo_ie_reg <= pwdata[PTM_LO_IE_BIT];
          hi_ie_reg <= pwdata[PTM_HI_IE_BIT];
          lo_ip_reg <= pwdata[PTM_LO_IP_LO +: PTM_IP_W];
          hi_ip_reg <= pwdata[PTM_HI_IP_LO +: PTM_IP_W];
        end
        default: lo_period_reg <= lo_period_reg;
      endcase
    end
  end

  // Flags: set wins over a software clear (write 1 to clear)
  logic irq_wr;
  assign irq_wr = wr_en && (paddr == PTM_IRQ_OFS);
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      lo_if_reg <= 1'b0;
      hi_if_reg <= 1'b0;
    end
    else
    begin
      lo_if_reg <= lo_event || (lo_if_reg && !(irq_wr && pwdata[PTM_LO_IF_BIT]));
      hi_if_reg <= hi_event || (hi_if_reg && !(irq_wr && pwdata[PTM_HI_IF_BIT]));
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      irq_lo <= 1'b0;
      irq_hi <= 1'b0;
      irq_priority_lo <= 3'h0;
      irq_priority_hi <= 3'h0;
    end
    else
    begin
      irq_lo <= lo_if_reg && lo_ie_reg && !concat;
      irq_hi <= hi_if_reg && hi_ie_reg;
      irq_priority_lo <= lo_ip_reg;
      irq_priority_hi <= hi_ip_reg;
    end
  end

  // Period event pulses
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      adc_trigger <= 1'b0;
      dma_req_lo <= 1'b0;
      dma_req_hi <= 1'b0;
    end
    else
    begin
      adc_trigger <= hi_event;
      dma_req_lo <= DMA_CAPABLE && lo_event;
      dma_req_hi <= DMA_CAPABLE && hi_event;
    end
  end

  // ----------------------------------------------------------------
  // APB slave: one wait-free access, answer registered
  // ----------------------------------------------------------------
  function automatic logic [31:0] ptm_word(input logic [15:0] v);
    ptm_word = {16'h0000, v};
  endfunction

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      apb_reg <= PTM_IDLE_PH;
      prdata <= PTM_ZERO32;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      case (apb_reg)
        PTM_IDLE_PH:
        begin
          if (psel && !penable)
          begin
            apb_reg <= PTM_ACCESS_PH;
            pready <= 1'b1;
            pslverr <= !addr_ok;
            prdata <= PTM_ZERO32;
            if (rd_en)
            begin
              case (paddr)
                PTM_LO_CTRL_OFS: prdata <= ptm_word(lo_ctrl_reg);
                PTM_HI_CTRL_OFS: prdata <= ptm_word(hi_ctrl_reg);
                PTM_LO_COUNT_OFS: prdata <= ptm_word(lo_count_reg);
                PTM_HI_COUNT_OFS: prdata <= ptm_word(hi_count_reg);
                PTM_LO_PERIOD_OFS: prdata <= ptm_word(lo_period_reg);
                PTM_HI_PERIOD_OFS: prdata <= ptm_word(hi_period_reg);
                PTM_IRQ_OFS: prdata <= {19'h00000, hi_ip_reg, hi_if_reg, hi_ie_reg,
                                        3'h0, lo_ip_reg, lo_if_reg, lo_ie_reg};
                default: prdata <= PTM_ZERO32;
              endcase
            end
          end
        end
        PTM_ACCESS_PH:
          apb_reg <= PTM_IDLE_PH;
        default:
          apb_reg <= PTM_IDLE_PH;
      endcase
    end
  end
endmodule
`default_nettype wire

// File: tb/ptm_pin_model.sv
/*
  External count pin: sends a burst of rising edges on request.
  Assumes go is a one-cycle pulse and n_edges is not zero.
*/
`timescale 1ns/1ns
`default_nettype none
module ptm_pin_model
(
  input wire logic pclk,
  input wire logic go,
  input wire logic [7:0] n_edges,
  output logic pin,
  output logic busy
);
  logic [7:0] left_reg = 8'h00;
  logic [2:0] ph_reg = 3'h0;
  initial pin = 1'b0;
  initial busy = 1'b0;
  // Eight clocks per pulse, idle low between bursts
  always @(posedge pclk)
  begin
    if (go && !busy)
    begin
      left_reg <= n_edges;
      ph_reg <= 3'h0;
      busy <= 1'b1;
    end
    else if (busy)
    begin
      ph_reg <= ph_reg + 3'h1;
      if (ph_reg == 3'h3)
        pin <= 1'b1;
      if (ph_reg == 3'h7)
      begin
        pin <= 1'b0;
        left_reg <= left_reg - 8'h01;
        busy <= (left_reg != 8'h01);
      end
    end
  end
endmodule
`default_nettype wire

// File: tb/ptm_timer_pair_props.sv
/*
  Port checker for the paired timer block: APB timing, control read masks,
  joined-mode interrupt steering and transfer request gating.
  Assumes it is bound onto ptm_timer_pair and sees only its ports.
*/
`timescale 1ns/1ns
`default_nettype none
module ptm_timer_pair_props
  import ptm_pkg::*;
#(
  parameter bit DMA_CAPABLE = 1'b1
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic irq_lo,
  input wire logic [2:0] irq_priority_hi,
  input wire logic dma_req_lo,
  input wire logic dma_req_hi
);
  logic join_reg;
  logic [2:0] pri_reg;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence setup_s;
    psel && !penable;
  endsequence
  sequence done_s;
    psel && penable && pready;
  endsequence
  // ----------------------------------------------------------------
  // Shadow of written low control join bit and high-word interrupt priority
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      join_reg <= 1'b0;
    else if (psel && penable && pready && pwrite && paddr == PTM_LO_CTRL_OFS)
      join_reg <= pwdata[PTM_CONCAT_BIT];
  end
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pri_reg <= 3'h0;
    else if (psel && penable && pready && pwrite && paddr == PTM_IRQ_OFS)
      pri_reg <= pwdata[PTM_HI_IP_LO +: PTM_IP_W];
  end
  zero_wait_a: assert property (setup_s |=> pready) else $error("no ready after setup");
  ready_pulse_a: assert property (pready |=> !pready) else $error("ready held too long");
  unmapped_err_a: assert property (setup_s ##0 (paddr > PTM_IRQ_OFS) |=> pslverr)
    else $error("unmapped access without error");
  mapped_ok_a: assert property (setup_s ##0 (paddr <= PTM_IRQ_OFS && paddr[1:0] == 2'h0)
    |=> !pslverr) else $error("mapped access flagged");
  upper_zero_a: assert property (pready && !pwrite |-> prdata[31:16] == 16'h0000)
    else $error("upper read half not zero");
  lo_ctrl_bits_a: assert property (done_s ##0 (!pwrite && paddr == PTM_LO_CTRL_OFS) |->
    (prdata[15:0] & ~PTM_LO_CTRL_MASK) == 16'h0000) else $error("low control stray bits");
  hi_ctrl_bits_a: assert property (done_s ##0 (!pwrite && paddr == PTM_HI_CTRL_OFS) |->
    (prdata[15:0] & ~PTM_HI_CTRL_MASK) == 16'h0000) else $error("high control stray bits");
  join_irq_a: assert property (join_reg && $past(join_reg) |-> !irq_lo)
    else $error("low interrupt while joined");
  prio_copy_a: assert property (done_s ##0 (pwrite && paddr == PTM_IRQ_OFS) |->
    ##[1:2] irq_priority_hi == pri_reg) else $error("priority copy wrong");
  dma_cap_a: assert property ((dma_req_lo || dma_req_hi) |-> DMA_CAPABLE)
    else $error("transfer request from incapable pair");
  join_dma_a: assert property (join_reg && $past(join_reg) |-> !dma_req_lo)
    else $error("low transfer request while joined");
endmodule
bind ptm_timer_pair ptm_timer_pair_props #(.DMA_CAPABLE(DMA_CAPABLE)) u_ptm_timer_pair_props (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .irq_lo(irq_lo), .irq_priority_hi(irq_priority_hi), .dma_req_lo(dma_req_lo),
  .dma_req_hi(dma_req_hi));
`default_nettype wire

// File: tb/ptm_timer_pair_tb.sv
/*
  Register-level bench for the paired timers: reset values, masks, prescale,
  gating, external counting, wrap events, joined mode and idle halt.
  Assumes the checker is bound and the pin models drive the count pins.
*/
`timescale 1ns/1ns
`default_nettype none
module ptm_timer_pair_tb;
  import ptm_pkg::*;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00, n_edges = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd, a, b;
  logic pready, pslverr, err, ext_count_pin_lo, ext_count_pin_hi, busy_lo, busy_hi;
  logic gate_pin_lo = 1'b0, gate_pin_hi = 1'b0, device_idle = 1'b0, go_lo = 1'b0, go_hi = 1'b0;
  logic irq_lo, irq_hi, adc_trigger, dma_req_lo, dma_req_hi;
  logic [2:0] irq_priority_lo, irq_priority_hi;
  int failures = 0, num_checks = 0, adc_seen = 0, dma_seen = 0, s;
  int ratio [4] = '{1, 8, 64, 256};
  ptm_timer_pair u_ptm_timer_pair (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .ext_count_pin_lo(ext_count_pin_lo),
    .ext_count_pin_hi(ext_count_pin_hi), .gate_pin_lo(gate_pin_lo), .gate_pin_hi(gate_pin_hi),
    .device_idle(device_idle), .irq_lo(irq_lo), .irq_hi(irq_hi),
    .irq_priority_lo(irq_priority_lo), .irq_priority_hi(irq_priority_hi),
    .adc_trigger(adc_trigger), .dma_req_lo(dma_req_lo), .dma_req_hi(dma_req_hi));
  ptm_pin_model u_ptm_pin_model_lo (.pclk(pclk), .go(go_lo), .n_edges(n_edges),
    .pin(ext_count_pin_lo), .busy(busy_lo));
  ptm_pin_model u_ptm_pin_model_hi (.pclk(pclk), .go(go_hi), .n_edges(n_edges),
    .pin(ext_count_pin_hi), .busy(busy_hi));
  always #2 pclk = ~pclk;
  always @(posedge pclk)
  begin
    if (adc_trigger === 1'b1)
      adc_seen++;
    if (dma_req_hi === 1'b1)
      dma_seen++;
  end
  // ----------------------------------------------------------------
  // Bus and compare tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] data);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= addr;
    pwdata <= data;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    if (n >= 20)
    begin
      failures++;
      end_sim();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Count advance over exactly w clocks
  task automatic delta(input logic [7:0] addr, input int w);
    apb(1'b0, addr, 32'h0);
    a = rd;
    repeat (w - 3) @(posedge pclk);
    apb(1'b0, addr, 32'h0);
    b = (rd - a) & 32'hFFFF;
  endtask
  task automatic end_sim;
    $display("Checks %0d, mismatches %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial
  begin
    #80000;
    failures++;
    end_sim();
  end
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial
  begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 7; i++)
    begin
      apb(1'b0, 8'(i * 4), 32'h0);
      check(rd, (i == 4 || i == 5) ? 32'h0000FFFF : 32'h0);
    end
    apb(1'b1, PTM_LO_CTRL_OFS, 32'h00007FFF);
    apb(1'b0, PTM_LO_CTRL_OFS, 32'h0);
    check(rd, 32'h0000207A);
    apb(1'b1, PTM_HI_CTRL_OFS, 32'h00007FFF);
    apb(1'b0, PTM_HI_CTRL_OFS, 32'h0);
    check(rd, 32'h00002072);
    apb(1'b1, 8'h1C, 32'h0000FFFF);
    apb(1'b0, 8'h1C, 32'h0);
    check(rd, 32'h0);
    check({31'h0, err}, 32'h1);
    apb(1'b1, PTM_HI_CTRL_OFS, 32'h0);
    for (int p = 0; p < 4; p++)
    begin
      apb(1'b1, PTM_LO_CTRL_OFS, 32'h8000 | (p << 4));
      delta(PTM_LO_COUNT_OFS, 4 * ratio[p]);
      check(b, 32'h4);
    end
    apb(1'b1, PTM_LO_CTRL_OFS, 32'h0);
    delta(PTM_LO_COUNT_OFS, 16);
    check(b, 32'h0);
    apb(1'b1, PTM_LO_CTRL_OFS, 32'h00008040);
    delta(PTM_LO_COUNT_OFS, 16);
    check(b, 32'h0);
    gate_pin_lo <= 1'b1;
    repeat (8) @(posedge pclk);
    delta(PTM_LO_COUNT_OFS, 16);
    check(b, 32'h10);
    gate_pin_lo <= 1'b0;
    for (int t = 0; t < 2; t++)
    begin
      apb(1'b1, t ? PTM_HI_CTRL_OFS : PTM_LO_CTRL_OFS, 32'h00008042);
      apb(1'b0, t ? PTM_HI_COUNT_OFS : PTM_LO_COUNT_OFS, 32'h0);
      a = rd;
      n_edges <= 8'h05;
      go_lo <= (t == 0);
      go_hi <= (t == 1);
      @(posedge pclk);
      go_lo <= 1'b0;
      go_hi <= 1'b0;
      @(posedge pclk);
      while (busy_lo || busy_hi) @(posedge pclk);
      repeat (8) @(posedge pclk);
      apb(1'b0, t ? PTM_HI_COUNT_OFS : PTM_LO_COUNT_OFS, 32'h0);
      check((rd - a) & 32'hFFFF, 32'h5);
    end
    apb(1'b1, PTM_LO_CTRL_OFS, 32'h0);
    apb(1'b1, PTM_HI_CTRL_OFS, 32'h0);
    apb(1'b1, PTM_HI_PERIOD_OFS, 32'h3);
    apb(1'b1, PTM_HI_COUNT_OFS, 32'h0);
    apb(1'b1, PTM_IRQ_OFS, 32'h00001500);
    apb(1'b1, PTM_HI_CTRL_OFS, 32'h00008000);
    s = adc_seen;
    repeat (42) @(posedge pclk);
    check(adc_seen - s, 32'd10);
    check(irq_hi, 1'b1);
    check({29'h0, irq_priority_hi}, 32'h5);
    check(dma_seen > 0, 32'h1);
    apb(1'b1, PTM_HI_CTRL_OFS, 32'h0);
    apb(1'b1, PTM_IRQ_OFS, 32'h0000170C);
    apb(1'b0, PTM_IRQ_OFS, 32'h0);
    check(rd, 32'h0000150C);
    check({29'h0, irq_priority_lo}, 32'h3);
    apb(1'b1, PTM_HI_PERIOD_OFS, 32'h0);
    apb(1'b1, PTM_LO_PERIOD_OFS, 32'h0000000F);
    apb(1'b1, PTM_HI_COUNT_OFS, 32'h0);
    apb(1'b1, PTM_LO_COUNT_OFS, 32'h0);
    apb(1'b1, PTM_IRQ_OFS, 32'h00000101);
    apb(1'b1, PTM_HI_CTRL_OFS, 32'h00000032);
    apb(1'b1, PTM_LO_CTRL_OFS, 32'h00008008);
    s = adc_seen;
    repeat (66) @(posedge pclk);
    check(adc_seen - s, 32'd4);
    apb(1'b0, PTM_IRQ_OFS, 32'h0);
    check(rd, 32'h00000301);
    check(irq_lo, 1'b0);
    apb(1'b1, PTM_LO_CTRL_OFS, 32'h00000008);
    apb(1'b1, PTM_HI_PERIOD_OFS, 32'h0000FFFF);
    apb(1'b1, PTM_LO_PERIOD_OFS, 32'h0000FFFF);
    apb(1'b1, PTM_LO_COUNT_OFS, 32'h0000FFFE);
    apb(1'b1, PTM_HI_COUNT_OFS, 32'h0);
    apb(1'b1, PTM_LO_CTRL_OFS, 32'h00008008);
    apb(1'b1, PTM_LO_CTRL_OFS, 32'h00000008);
    apb(1'b0, PTM_HI_COUNT_OFS, 32'h0);
    check(rd, 32'h1);
    apb(1'b1, PTM_HI_CTRL_OFS, 32'h00002000);
    apb(1'b1, PTM_LO_CTRL_OFS, 32'h00008008);
    device_idle <= 1'b1;
    delta(PTM_LO_COUNT_OFS, 16);
    check(b, 32'h0);
    apb(1'b1, PTM_HI_CTRL_OFS, 32'h0);
    delta(PTM_LO_COUNT_OFS, 16);
    check(b, 32'h10);
    device_idle <= 1'b0;
    end_sim();
  end
endmodule
`default_nettype wire
